/* File: hw/nna_alu_top.sv */
// Execute stage for integer negate, integer and float parallel negate with store,
// no-operation and normalize, plus an AXI4-Lite slave for mode and flags.
// Assumes the decoder presents the word and all operands in one valid cycle.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// - Float negate with store decodes 1110001, zeros.
// - Parallel registers read at start, written end.
// - Negate operand read precedes the store write.
// - Flags change only for destinations R0-R7.
// - Float negate sets latched flags, event flags.
// - Saturate mode ignored by float, nop, normalize.
// - Integer negate: zero minus source, four modes.
// - Integer negate: overflow, latched, carry, underflow cleared.
// - Integer negate saturates on overflow when enabled.
// - Integer negate with store decodes 1110010.
// - Parallel forms use R0-R7, indirect memory.
// - Indirect offset: 8-bit displacement or index.
// - Indirect nop updates address, dummy read.
// - Plain nop only advances program counter.
// - Normalize: implied bit is sign, shift left.
// - Exponent -128, zero mantissa: zero, Z set.
// - Exponent -128, nonzero mantissa: zero, underflow.
// - Underflow or zero mantissa gives exponent -128.
// - Normalize underflow sets latched underflow flag.
module nna_alu_top (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ex_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [39:0] reg_op_i,
  input wire logic [39:0] mem_op_i,
  input wire logic [39:0] st_reg_i,
  input wire logic [31:0] index_reg_zero_i,
  input wire logic [31:0] index_reg_one_i,
  output logic rf_we_o,
  output logic [4:0] rf_waddr_o,
  output logic [39:0] rf_wdata_o,
  output logic st_we_o,
  output logic [39:0] st_wdata_o,
  output logic ar_upd_o,
  output logic [2:0] ar_sel_o,
  output logic [31:0] addr_off_o,
  output logic dummy_rd_o,
  output logic pc_adv_o,
  output logic [6:0] flags_o,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode and operand selection.

  nna_pkg::nna_op_t op; // Operation of the current execute cycle.
  logic [1:0] gmode; // Addressing mode of standalone forms.
  logic par; // A parallel negate-plus-store form.
  logic [4:0] dst; // Result register number.
  logic ext_dst; // Result lands in one of the eight extended registers.
  logic [39:0] src; // Selected negate or normalize source.
  logic saturate_mode_bit; // Software-controlled integer saturation.

  // Reserved bits 21..19 must be zero or the parallel form is not recognised.
  always_comb begin
    op = nna_pkg::OP_NONE;
    if (ex_valid_i) begin
      if (instr_i[nna_pkg::PAR_OPC_LSB +: 7] == nna_pkg::OPC_FNEG_STF
          && instr_i[nna_pkg::PAR_ZERO_LSB +: 3] == 3'h0) begin
        op = nna_pkg::OP_FNEG_PAR;
      end else if (instr_i[nna_pkg::PAR_OPC_LSB +: 7] == nna_pkg::OPC_INEG_STI
          && instr_i[nna_pkg::PAR_ZERO_LSB +: 3] == 3'h0) begin
        op = nna_pkg::OP_INEG_PAR;
      end else if (instr_i[nna_pkg::STD_OPC_LSB +: 9] == nna_pkg::OPC_INEG) begin
        op = nna_pkg::OP_INEG;
      end else if (instr_i[nna_pkg::STD_OPC_LSB +: 9] == nna_pkg::OPC_NOP) begin
        op = nna_pkg::OP_NOP;
      end else if (instr_i[nna_pkg::STD_OPC_LSB +: 9] == nna_pkg::OPC_NORM) begin
        op = nna_pkg::OP_NORM;
      end
    end
  end

  // Parallel forms carry a 3-bit destination, so only R0-R7 can be named there.
  always_comb begin
    gmode = instr_i[nna_pkg::G_LSB +: 2];
    par = (op == nna_pkg::OP_FNEG_PAR) || (op == nna_pkg::OP_INEG_PAR);
    dst = par ? {2'b00, instr_i[nna_pkg::PAR_DST1_LSB +: 3]} : instr_i[nna_pkg::DST_LSB +: 5];
    ext_dst = (dst < nna_pkg::NUM_EXT_REGS);
  end

  // The parallel negate source is always the indirect memory operand.
  // Immediates are a signed integer for negate and a short float for normalize.
  always_comb begin
    if (par) begin
      src = mem_op_i;
    end else begin
      unique case (gmode)
        nna_pkg::G_REG: src = reg_op_i;
        nna_pkg::G_DIR,
        nna_pkg::G_IND: src = mem_op_i;
        nna_pkg::G_IMM: begin
          if (op == nna_pkg::OP_NORM) begin
            src = {{4{instr_i[15]}}, instr_i[15:12], instr_i[11:0], 20'h00000};
          end else begin
            src = {8'h00, {16{instr_i[15]}}, instr_i[15:0]};
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic.

  logic [31:0] ineg_res; // Integer result after optional saturation.
  logic ineg_ovf; // Only the most negative integer overflows.
  logic ineg_borrow; // Zero minus anything nonzero borrows.
  logic [7:0] fn_exp;
  logic [31:0] fn_man;
  logic fn_uf;
  logic fn_ov;
  logic [7:0] nm_exp;
  logic [31:0] nm_man;
  logic nm_uf;
  logic nm_z;

  // Saturation is applied here and nowhere in the float or normalize paths.
  always_comb begin
    ineg_ovf = (src[31:0] == nna_pkg::INT_MIN);
    ineg_borrow = (src[31:0] != 32'h00000000);
    ineg_res = 32'h00000000 - src[31:0];
    if (ineg_ovf && saturate_mode_bit) begin
      ineg_res = nna_pkg::INT_MAX;
    end
  end

  // Float negate unit; saturation mode is deliberately not wired in.
  nna_fneg u_fneg (
    .exp_i(src[39:32]),
    .man_i(src[31:0]),
    .exp_o(fn_exp),
    .man_o(fn_man),
    .uf_o(fn_uf),
    .ov_o(fn_ov)
  );

  // Normalize unit.
  nna_norm u_norm (
    .exp_i(src[39:32]),
    .man_i(src[31:0]),
    .exp_o(nm_exp),
    .man_o(nm_man),
    .uf_o(nm_uf),
    .z_o(nm_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write-back at the end of the execute cycle.

  logic rf_we_r;
  logic [4:0] rf_waddr_r;
  logic [39:0] rf_wdata_r;
  logic st_we_r;
  logic [39:0] st_wdata_r;
  logic pc_adv_r;

  // Every operand was taken from this cycle's inputs; results leave one edge later,
  // so a store never sees the value the parallel negate is about to write.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rf_we_r <= 1'b0;
      rf_waddr_r <= 5'h00;
      rf_wdata_r <= 40'h0000000000;
      st_we_r <= 1'b0;
      st_wdata_r <= 40'h0000000000;
      pc_adv_r <= 1'b0;
    end else begin
      rf_we_r <= (op != nna_pkg::OP_NONE) && (op != nna_pkg::OP_NOP);
      rf_waddr_r <= dst;
      pc_adv_r <= (op != nna_pkg::OP_NONE);
      st_we_r <= par;
      st_wdata_r <= st_reg_i;
      unique case (op)
        nna_pkg::OP_FNEG_PAR: rf_wdata_r <= {fn_exp, fn_man};
        nna_pkg::OP_INEG,
        nna_pkg::OP_INEG_PAR: rf_wdata_r <= {8'h00, ineg_res};
        nna_pkg::OP_NORM: rf_wdata_r <= {nm_exp, nm_man};
        nna_pkg::OP_NONE,
        nna_pkg::OP_NOP: rf_wdata_r <= rf_wdata_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address-register update for the indirect no-operation.

  logic ar_upd_r;
  logic [2:0] ar_sel_r;
  logic [31:0] addr_off_r;
  logic dummy_rd_r;
  logic [1:0] ofs_sel;

  // The offset choice sits in the top two bits of the modify field.
  always_comb begin
    ofs_sel = instr_i[nna_pkg::MOD_LSB + 3 +: 2];
  end

  // Only the address unit and the memory see this; no result or flag moves.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ar_upd_r <= 1'b0;
      ar_sel_r <= 3'h0;
      addr_off_r <= 32'h00000000;
      dummy_rd_r <= 1'b0;
    end else begin
      ar_upd_r <= (op == nna_pkg::OP_NOP) && (gmode == nna_pkg::G_IND);
      dummy_rd_r <= (op == nna_pkg::OP_NOP) && (gmode == nna_pkg::G_IND);
      ar_sel_r <= instr_i[nna_pkg::ARN_LSB +: 3];
      if (ofs_sel == nna_pkg::OFS_IDX0) begin
        addr_off_r <= index_reg_zero_i;
      end else if (ofs_sel == nna_pkg::OFS_IDX1) begin
        addr_off_r <= index_reg_one_i;
      end else begin
        addr_off_r <= {24'h000000, instr_i[7:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.

  logic [6:0] flags_r;
  logic stat_wr; // Software write to the status word this cycle.
  logic wr_fire;

  // Software clears latched flags first; a set in the same cycle overrides it.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flags_r <= nna_pkg::FLAGS_RST;
    end else begin
      if (stat_wr && s_axi_wdata_i[nna_pkg::FLG_LUF]) begin
        flags_r[nna_pkg::FLG_LUF] <= 1'b0;
      end
      if (stat_wr && s_axi_wdata_i[nna_pkg::FLG_LV]) begin
        flags_r[nna_pkg::FLG_LV] <= 1'b0;
      end
      if (ext_dst) begin
        unique case (op)
          nna_pkg::OP_FNEG_PAR: begin
            if (fn_uf) flags_r[nna_pkg::FLG_LUF] <= 1'b1;
            if (fn_ov) flags_r[nna_pkg::FLG_LV] <= 1'b1;
            flags_r[nna_pkg::FLG_UF] <= fn_uf;
            flags_r[nna_pkg::FLG_V] <= fn_ov;
            flags_r[nna_pkg::FLG_N] <= fn_man[31];
            flags_r[nna_pkg::FLG_Z] <= (fn_exp == nna_pkg::EXP_ZERO);
          end
          nna_pkg::OP_INEG,
          nna_pkg::OP_INEG_PAR: begin
            if (ineg_ovf) flags_r[nna_pkg::FLG_LV] <= 1'b1;
            flags_r[nna_pkg::FLG_V] <= ineg_ovf;
            flags_r[nna_pkg::FLG_C] <= ineg_borrow;
            flags_r[nna_pkg::FLG_UF] <= 1'b0;
            flags_r[nna_pkg::FLG_N] <= ineg_res[31];
            flags_r[nna_pkg::FLG_Z] <= (ineg_res == 32'h00000000);
          end
          nna_pkg::OP_NORM: begin
            if (nm_uf) flags_r[nna_pkg::FLG_LUF] <= 1'b1;
            flags_r[nna_pkg::FLG_UF] <= nm_uf;
            flags_r[nna_pkg::FLG_V] <= 1'b0;
            flags_r[nna_pkg::FLG_N] <= nm_man[31];
            flags_r[nna_pkg::FLG_Z] <= nm_z;
          end
          nna_pkg::OP_NONE,
          nna_pkg::OP_NOP: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic sat_r;
  logic rd_fire;

  // Address and data are taken together, which keeps one write in flight.
  always_comb begin
    wr_fire = awready_r && s_axi_awvalid_i && s_axi_wvalid_i;
    rd_fire = arready_r && s_axi_arvalid_i;
    stat_wr = wr_fire && s_axi_awaddr_i[3:2] == nna_pkg::REG_STAT && s_axi_wstrb_i[0];
    saturate_mode_bit = sat_r;
  end

  // Write channel: one-cycle ready pulse, response on the following edge.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= nna_pkg::RESP_OKAY;
      sat_r <= nna_pkg::CTRL_SAT_RST;
    end else begin
      awready_r <= s_axi_awvalid_i && s_axi_wvalid_i && !awready_r && !bvalid_r;
      wready_r <= s_axi_awvalid_i && s_axi_wvalid_i && !awready_r && !bvalid_r;
      if (bvalid_r && s_axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= (s_axi_awaddr_i[3] == 1'b0) ? nna_pkg::RESP_OKAY : nna_pkg::RESP_SLVERR;
        if (s_axi_awaddr_i[3:2] == nna_pkg::REG_CTRL && s_axi_wstrb_i[0]) begin
          sat_r <= s_axi_wdata_i[nna_pkg::CTRL_SAT];
        end
      end
    end
  end

  // Read channel: unmapped words read zero with an error response.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= nna_pkg::RESP_OKAY;
    end else begin
      arready_r <= s_axi_arvalid_i && !arready_r && !rvalid_r;
      if (rvalid_r && s_axi_rready_i) begin
        rvalid_r <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rresp_r <= (s_axi_araddr_i[3] == 1'b0) ? nna_pkg::RESP_OKAY : nna_pkg::RESP_SLVERR;
        unique case (s_axi_araddr_i[3:2])
          nna_pkg::REG_CTRL: rdata_r <= {31'h00000000, sat_r};
          nna_pkg::REG_STAT: rdata_r <= {25'h0000000, flags_r};
          default: rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // Output drive, all straight from flip-flops.
  assign rf_we_o = rf_we_r;
  assign rf_waddr_o = rf_waddr_r;
  assign rf_wdata_o = rf_wdata_r;
  assign st_we_o = st_we_r;
  assign st_wdata_o = st_wdata_r;
  assign ar_upd_o = ar_upd_r;
  assign ar_sel_o = ar_sel_r;
  assign addr_off_o = addr_off_r;
  assign dummy_rd_o = dummy_rd_r;
  assign pc_adv_o = pc_adv_r;
  assign flags_o = flags_r;
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  AST_PAR_DECODE: assert property (
    op == nna_pkg::OP_FNEG_PAR |=> rf_we_o && st_we_o && pc_adv_o && rf_waddr_o < 5'h08
  ) else $error("parallel float negate not executed");

  AST_STORE_OLD: assert property (
    par |=> st_wdata_o == $past(st_reg_i)
  ) else $error("store did not use the pre-negate register value");

  AST_FLAGS_HOLD: assert property (
    (op != nna_pkg::OP_NONE && !ext_dst && !stat_wr) |=> $stable(flags_o)
  ) else $error("flags changed for a non-extended destination");

  AST_FNEG_LATCH: assert property (
    (op == nna_pkg::OP_FNEG_PAR && ext_dst && fn_uf) |=> flags_o[nna_pkg::FLG_LUF] && flags_o[nna_pkg::FLG_UF]
  ) else $error("float underflow did not set latched flag");

  AST_INEG_VALUE: assert property (
    (op == nna_pkg::OP_INEG && !ineg_ovf) |=> rf_wdata_o[31:0] + $past(src[31:0]) == 32'h00000000
  ) else $error("integer negate result wrong");

  AST_INEG_FLAGS: assert property (
    (par && op == nna_pkg::OP_INEG_PAR && ext_dst && ineg_ovf)
      |=> flags_o[nna_pkg::FLG_LV] && flags_o[nna_pkg::FLG_V] && !flags_o[nna_pkg::FLG_UF]
  ) else $error("integer overflow flags wrong");

  AST_SATURATE: assert property (
    (op == nna_pkg::OP_INEG && ineg_ovf && saturate_mode_bit) |=> rf_wdata_o[31:0] == nna_pkg::INT_MAX
  ) else $error("integer negate did not saturate");

  AST_NOP_IND: assert property (
    (op == nna_pkg::OP_NOP && gmode == nna_pkg::G_IND && !stat_wr)
      |=> ar_upd_o && dummy_rd_o && !rf_we_o && $stable(flags_o)
  ) else $error("indirect nop misbehaved");

  AST_NOP_PLAIN: assert property (
    (op == nna_pkg::OP_NOP && gmode == nna_pkg::G_REG) |=> pc_adv_o && !ar_upd_o && !rf_we_o && !st_we_o
  ) else $error("plain nop did more than advance");

  AST_NORM_UF: assert property (
    (op == nna_pkg::OP_NORM && ext_dst && src[39:32] == nna_pkg::EXP_ZERO && src[31:0] != 32'h00000000)
      |=> rf_wdata_o == {nna_pkg::EXP_ZERO, 32'h00000000} && !flags_o[nna_pkg::FLG_Z] && flags_o[nna_pkg::FLG_UF]
  ) else $error("normalize of unnormal zero wrong");

  AST_AXI_B: assert property (
    wr_fire |=> s_axi_bvalid_o
  ) else $error("write response missing");

  COV_FNEG: cover property (op == nna_pkg::OP_FNEG_PAR ##1 st_we_o);
  COV_INEG_OVF: cover property (op == nna_pkg::OP_INEG && ineg_ovf);
  COV_NORM: cover property (op == nna_pkg::OP_NORM && nm_uf);

endmodule

/* File: include/nna_pkg.sv */
// Shared constants and types for the negate, normalize and no-operation execute datapath.
// Assumes a 40-bit extended register format: signed 8-bit exponent over a 32-bit mantissa.
package nna_pkg;

  // Parallel negate-plus-store opcodes in bits 31..25.
  localparam logic [6:0] OPC_FNEG_STF = 7'h71;
  localparam logic [6:0] OPC_INEG_STI = 7'h72;
  // Standalone opcodes in bits 31..23.
  localparam logic [8:0] OPC_INEG = 9'h018;
  localparam logic [8:0] OPC_NOP = 9'h019;
  localparam logic [8:0] OPC_NORM = 9'h01A;

  // Instruction field positions.
  localparam int PAR_OPC_LSB = 25;
  localparam int STD_OPC_LSB = 23;
  localparam int PAR_DST1_LSB = 22;
  localparam int PAR_ZERO_LSB = 19;
  localparam int G_LSB = 21;
  localparam int DST_LSB = 16;
  localparam int MOD_LSB = 11;
  localparam int ARN_LSB = 8;

  // General addressing modes.
  localparam logic [1:0] G_REG = 2'h0;
  localparam logic [1:0] G_DIR = 2'h1;
  localparam logic [1:0] G_IND = 2'h2;
  localparam logic [1:0] G_IMM = 2'h3;

  // Offset selection in the upper bits of the indirect modify field.
  localparam logic [1:0] OFS_IDX0 = 2'h2;
  localparam logic [1:0] OFS_IDX1 = 2'h3;

  // Number formats.
  localparam logic [7:0] EXP_ZERO = 8'h80;
  localparam logic [7:0] EXP_MAX = 8'h7F;
  localparam logic [31:0] INT_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] INT_MIN = 32'h80000000;
  localparam logic [4:0] NUM_EXT_REGS = 5'h08;

  // Register map and field layout of the status word.
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam int CTRL_SAT = 0;
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_UF = 4;
  localparam int FLG_LV = 5;
  localparam int FLG_LUF = 6;
  localparam logic [6:0] FLAGS_RST = 7'h00;
  localparam logic CTRL_SAT_RST = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation selected in the execute cycle.
  typedef enum logic [2:0] {
    OP_NONE, OP_FNEG_PAR, OP_INEG, OP_INEG_PAR, OP_NOP, OP_NORM
  } nna_op_t;

endpackage

/* File: hw/nna_fneg.sv */
// Floating-point negate of one extended-precision operand, purely combinational.
// Assumes the caller registers the result and applies the flag policy.
`timescale 1ns/1ps

module nna_fneg (
  input wire logic [7:0] exp_i,
  input wire logic [31:0] man_i,
  output logic [7:0] exp_o,
  output logic [31:0] man_o,
  output logic uf_o,
  output logic ov_o
);

  // Widened two's complement significand with the implied bit made explicit.
  logic [33:0] sig;
  logic [33:0] neg;
  logic [8:0] ex;
  logic [31:0] m;

  // Negation can grow the magnitude by one bit or shrink it by one, never more.
  always_comb begin
    sig = {man_i[31], man_i[31], ~man_i[31], man_i[30:0]};
    neg = 34'h0 - sig;
    ex = {exp_i[7], exp_i};
    if (neg[33] != neg[32]) begin
      ex = ex + 9'h001;
      m = {neg[33], neg[31:1]};
    end else if (neg[32] != neg[31]) begin
      m = {neg[32], neg[30:0]};
    end else begin
      ex = ex - 9'h001;
      m = {neg[32], neg[29:0], 1'b0};
    end
    uf_o = 1'b0;
    ov_o = 1'b0;
    exp_o = ex[7:0];
    man_o = m;
    if (exp_i == nna_pkg::EXP_ZERO) begin
      // A zero operand stays zero and raises nothing.
      exp_o = nna_pkg::EXP_ZERO;
      man_o = 32'h00000000;
    end else if (ex[8:7] == 2'b10) begin
      uf_o = 1'b1;
      exp_o = nna_pkg::EXP_ZERO;
      man_o = 32'h00000000;
    end else if (ex[8:7] == 2'b01) begin
      // Overflow clamps to the largest magnitude of the result's sign.
      ov_o = 1'b1;
      exp_o = nna_pkg::EXP_MAX;
      man_o = m[31] ? nna_pkg::INT_MIN : nna_pkg::INT_MAX;
    end
  end

endmodule

/* File: hw/nna_norm.sv */
// Mantissa normalization of one extended-precision operand, purely combinational.
// Assumes the caller registers the result and applies the flag policy.
`timescale 1ns/1ps

module nna_norm (
  input wire logic [7:0] exp_i,
  input wire logic [31:0] man_i,
  output logic [7:0] exp_o,
  output logic [31:0] man_o,
  output logic uf_o,
  output logic z_o
);

  // Left shift that brings the first bit unlike the sign into the implied position.
  function automatic logic [5:0] lead_shift(input logic [32:0] s);
    logic [5:0] k;
    logic hit;
    k = 6'd32;
    hit = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!hit && s[i] != s[32]) begin
        k = 6'(31 - i);
        hit = 1'b1;
      end
    end
    return k;
  endfunction

  logic [32:0] sig;
  logic [32:0] sh;
  logic [5:0] k;
  logic [8:0] ex;

  // The implied bit equals the sign, so at least one shift is always needed.
  always_comb begin
    sig = {man_i[31], man_i[31], man_i[30:0]};
    k = lead_shift(sig);
    sh = sig << k;
    ex = {exp_i[7], exp_i} - {3'h0, k};
    exp_o = ex[7:0];
    man_o = {sh[32], sh[30:0]};
    uf_o = 1'b0;
    z_o = 1'b0;
    if (exp_i == nna_pkg::EXP_ZERO) begin
      // Zero result either way; only the flags tell the two cases apart.
      exp_o = nna_pkg::EXP_ZERO;
      man_o = 32'h00000000;
      z_o = (man_i == 32'h00000000);
      uf_o = (man_i != 32'h00000000);
    end else if (man_i == 32'h00000000 || ex[8:7] == 2'b10) begin
      exp_o = nna_pkg::EXP_ZERO;
      man_o = 32'h00000000;
      z_o = 1'b1;
      uf_o = (man_i != 32'h00000000);
    end
  end

endmodule

/* File: test/nna_mem_model.sv */
// Operand memory model: one word read as the negate source and written by the store.
// Assumes the bench preloads the word and the store pulse comes from the execute stage.
`timescale 1ns/1ps
module nna_mem_model (
  input wire logic mclk_i,
  input wire logic ld_i,
  input wire logic [39:0] ld_data_i,
  input wire logic st_we_i,
  input wire logic [39:0] st_wdata_i,
  output logic [39:0] mem_op_o
);
  // The word changes only after the store lands, so a shared location reads old data.
  always_ff @(posedge mclk_i) begin
    if (ld_i) begin
      mem_op_o <= ld_data_i;
    end else if (st_we_i) begin
      mem_op_o <= st_wdata_i;
    end
  end
endmodule

/* File: test/test_negate_normalize_alu_ops.sv */
// Self-checking bench for the negate, normalize and no-operation stage.
// Assumes the package, the design and the memory model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_negate_normalize_alu_ops;
  logic mclk_i = 0, srst_i = 1, ex_valid_i = 0, ld_i = 0;
  logic [31:0] instr_i = 0, index_reg_zero_i = 0, index_reg_one_i = 0, s_axi_wdata_i = 0, s_axi_rdata_o, x, addr_off_o;
  logic [39:0] reg_op_i = 0, st_reg_i = 0, ld_data_i = 0, mem_op_i, rf_wdata_o, st_wdata_o;
  logic [3:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_arvalid_i = 0, s_axi_bready_i = 1, s_axi_rready_i = 1;
  logic rf_we_o, st_we_o, ar_upd_o, dummy_rd_o, pc_adv_o, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [4:0] rf_waddr_o;
  logic [2:0] ar_sel_o;
  logic [6:0] flags_o, ef;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  int checks = 0, bad_count = 0, cyc = 0, seed = 72;
  nna_alu_top nna_alu_top_i (.*);
  nna_mem_model nna_mem_model_i (.mclk_i, .ld_i, .ld_data_i, .st_we_i(st_we_o), .st_wdata_i(st_wdata_o),
    .mem_op_o(mem_op_i));
  always #12.5 mclk_i = ~mclk_i;
  // A hang is cut short here; the ceiling is far above the real run length.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One execute cycle; outputs are looked at half a cycle after they register.
  task automatic ex(input logic [31:0] w, input logic [39:0] rop, input logic [39:0] sr);
    @(posedge mclk_i);
    instr_i <= w;
    reg_op_i <= rop;
    st_reg_i <= sr;
    index_reg_one_i <= $random(seed);
    ex_valid_i <= 1'b1;
    @(posedge mclk_i);
    ex_valid_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  // Register write: address and data offered together, held until taken.
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do @(posedge mclk_i); while (s_axi_awready_o !== 1'b1);
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i <= 1'b0;
    do @(posedge mclk_i); while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
  endtask
  task automatic axr(input logic [3:0] a, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do @(posedge mclk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge mclk_i); while (s_axi_rvalid_o !== 1'b1);
    r = s_axi_rresp_o;
  endtask
  // Zero minus a signed integer, clamped to the top positive value when saturating.
  function automatic logic [31:0] neg(input logic [31:0] v, input logic sat);
    return (sat && v == nna_pkg::INT_MIN) ? nna_pkg::INT_MAX : 32'h0 - v;
  endfunction
  function automatic logic [6:0] fneg(input logic [31:0] v, input logic [31:0] r, input logic [6:0] o);
    return {o[6], o[5] | (v == nna_pkg::INT_MIN), 1'b0, r[31], r == 0, v == nna_pkg::INT_MIN, v != 0};
  endfunction
  initial begin
    ef = nna_pkg::FLAGS_RST;
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    `CHK(flags_o, ef)
    // Integer negate from a register, corners first, plain then saturating.
    for (int i = 0; i < 14; i++) begin
      x = (i == 0) ? 32'h0 : (i == 1 || i == 13) ? nna_pkg::INT_MIN : $random(seed);
      if (i == 13) axw({nna_pkg::REG_CTRL, 2'h0}, 32'h1, rs);
      ex({nna_pkg::OPC_INEG, nna_pkg::G_REG, 5'h05, 16'h0000}, {8'h00, x}, 40'h0);
      `CHK(rf_wdata_o, {8'h00, neg(x, i == 13)})
      `CHK(flags_o, fneg(x, neg(x, i == 13), ef))
      ef = fneg(x, neg(x, i == 13), ef);
    end
    $display("test int_negate done");
    // Sticky overflow cleared by software; unmapped places answer with an error.
    axw({nna_pkg::REG_STAT, 2'h0}, 32'h20, rs);
    axr({nna_pkg::REG_STAT, 2'h0}, rs);
    ef[nna_pkg::FLG_LV] = 1'b0;
    `CHK(s_axi_rdata_o[6:0], ef)
    axw(4'h8, 32'h1, rs);
    `CHK(rs, nna_pkg::RESP_SLVERR)
    axr(4'hC, rs);
    `CHK(rs, nna_pkg::RESP_SLVERR)
    axw({nna_pkg::REG_CTRL, 2'h0}, 32'h1, rs);
    $display("test registers done");
    // Parallel negate with store: old store value, memory read before written.
    x = $random(seed);
    @(posedge mclk_i);
    ld_i <= 1'b1;
    ld_data_i <= {8'h00, x};
    ex({nna_pkg::OPC_INEG_STI, 3'h2, 3'h0, 3'h2, 8'h01, 8'h01}, 40'h0, 40'h00_1234_5678);
    ld_i <= 1'b0;
    `CHK(rf_wdata_o, {8'h00, neg(x, 1'b1)})
    `CHK({st_we_o, st_wdata_o}, {1'b1, 40'h00_1234_5678})
    ef = fneg(x, neg(x, 1'b1), ef);
    ex({nna_pkg::OPC_FNEG_STF, 3'h1, 3'h1, 19'h0}, 40'h0, 40'h0);
    `CHK({rf_we_o, st_we_o}, 2'b00)
    `CHK(mem_op_i, 40'h00_1234_5678)
    ex({nna_pkg::OPC_FNEG_STF, 3'h3, 3'h0, 3'h1, 8'h01, 8'h01}, 40'h0, 40'h0);
    ef[4:1] = 4'b0100;
    `CHK({rf_wdata_o, flags_o}, {40'h00_EDCB_A988, ef})
    $display("test parallel done");
    // No-operation: plain, then indirect with index and displacement offsets.
    ex({nna_pkg::OPC_NOP, nna_pkg::G_REG, 21'h0}, 40'h0, 40'h0);
    `CHK({pc_adv_o, ar_upd_o, dummy_rd_o, flags_o}, {3'b100, ef})
    ex({nna_pkg::OPC_NOP, nna_pkg::G_IND, 5'h00, 5'h18, 3'h4, 8'h00}, 40'h0, 40'h0);
    `CHK({ar_upd_o, dummy_rd_o, ar_sel_o, addr_off_o, flags_o}, {5'h1C, index_reg_one_i, ef})
    ex({nna_pkg::OPC_NOP, nna_pkg::G_IND, 10'h000, 3'h6, 8'hC5}, 40'h0, 40'h0);
    `CHK(addr_off_o, 32'h0000_00C5)
    $display("test nop done");
    // Normalize of the smallest exponent, zero then nonzero mantissa, then R9.
    ex({nna_pkg::OPC_NORM, nna_pkg::G_REG, 5'h01, 16'h0}, {nna_pkg::EXP_ZERO, 32'h0}, 40'h0);
    ef[4:1] = 4'b0010;
    `CHK({rf_wdata_o, flags_o}, {nna_pkg::EXP_ZERO, 32'h0, ef})
    ex({nna_pkg::OPC_NORM, nna_pkg::G_REG, 5'h01, 16'h0}, {nna_pkg::EXP_ZERO, 32'h1234}, 40'h0);
    ef[6] = 1'b1;
    ef[4:1] = 4'b1000;
    `CHK({rf_wdata_o, flags_o}, {nna_pkg::EXP_ZERO, 32'h0, ef})
    ex({nna_pkg::OPC_NORM, nna_pkg::G_REG, 5'h09, 16'h0}, {nna_pkg::EXP_ZERO, 32'h0}, 40'h0);
    `CHK(flags_o, ef)
    $display("test normalize done");
    summarize();
  end
endmodule
